// file: shared/pdfs_pkg.sv
// shared constants and types for the printhead data and fire sequencer
package pdfs_pkg;

  localparam int NUM_LANES = 8;
  localparam int NOZZLES_PER_ROW = 128;
  localparam int BITS_PER_GRAY_NOZZLE = 2;
  localparam int CLK_PERIOD_NS = 10;

  // times in their printed units
  localparam real T_FPDELAY_US = 13.8;
  localparam real T_BUSYEARLY_US = 3.5;
  localparam real T_MIN_GAP_US = 9.0;
  localparam real T_PULSE_MIN_US = 10.0;
  localparam real T_BUSYDELAY_NS = 100.0;

  // typical figures round to nearest, least figures round up, longest figures round down
  localparam int FPDELAY_CYC = int'(T_FPDELAY_US * 1000.0 / CLK_PERIOD_NS);
  localparam int BUSYEARLY_CYC = int'(T_BUSYEARLY_US * 1000.0 / CLK_PERIOD_NS);
  localparam int MIN_GAP_CYC = int'($ceil(T_MIN_GAP_US * 1000.0 / CLK_PERIOD_NS));
  localparam int PULSE_MIN_CYC = int'($ceil(T_PULSE_MIN_US * 1000.0 / CLK_PERIOD_NS));
  localparam int BUSYDELAY_CYC = int'($floor(T_BUSYDELAY_NS / CLK_PERIOD_NS));

  localparam int TIMER_W = 16;
  localparam int ROWCNT_W = 9;
  localparam int HITCNT_W = 8;

  localparam logic [TIMER_W-1:0] GAP_RST = 16'hFFFF;
  localparam logic [ROWCNT_W-1:0] ROW_BITS_BIN = 9'h080;
  localparam logic [ROWCNT_W-1:0] ROW_BITS_GRAY = 9'h100;

  // one finished row as seen at the lanes
  typedef struct packed {
    logic gray;
    logic [NUM_LANES-1:0] last_lsb;
    logic [NUM_LANES-1:0] last_msb;
    logic [NUM_LANES-1:0][HITCNT_W-1:0] hits;
  } pdfs_row_s;

  localparam pdfs_row_s ROW_RST = '0;

endpackage : pdfs_pkg

// file: design/pdfs_lane_capture.sv
// lane-side capture of nozzle data on the host shift clock
`timescale 1ns/100ps
module pdfs_lane_capture
  import pdfs_pkg::*;
(
  input wire logic lane_shift_clock, // host shift clock, data fetched on its falling edge
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic grayscale_mode, // mode pin, 1 = two bits per nozzle
  input wire logic [NUM_LANES-1:0] lane_data, // serial lanes
  output pdfs_row_s row_word, // last finished row
  output logic row_tgl // toggles once per finished row
);

  logic mode_meta_r;
  logic mode_r;
  logic [ROWCNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
  logic [NUM_LANES-1:0] lsb_r, lsb_nxt;
  logic [NUM_LANES-1:0][HITCNT_W-1:0] hits_r, hits_nxt;
  pdfs_row_s row_r, row_nxt;
  logic tgl_r, tgl_nxt;
  logic [ROWCNT_W-1:0] row_len;
  logic [NUM_LANES-1:0] lvl_nz;

  // mode pin is static between rows; synchronised because the shift clock is foreign to it
  always_ff @(negedge lane_shift_clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_meta_r <= 1'b0;
      mode_r <= 1'b0;
    end else begin
      mode_meta_r <= grayscale_mode;
      mode_r <= mode_meta_r;
    end
  end

  assign row_len = mode_r ? ROW_BITS_GRAY : ROW_BITS_BIN;

  assign lvl_nz = mode_r ? (lane_data | lsb_r) : lane_data;

  always_comb begin
    bit_cnt_nxt = bit_cnt_r + 9'h001;
    lsb_nxt = lsb_r;
    hits_nxt = hits_r;
    row_nxt = row_r;
    tgl_nxt = tgl_r;
    if (mode_r && !bit_cnt_r[0]) begin
      lsb_nxt = lane_data;
    end else begin
      for (int i = 0; i < NUM_LANES; i++) begin
        hits_nxt[i] = hits_r[i] + HITCNT_W'(lvl_nz[i]);
      end
    end
    if (bit_cnt_r >= row_len - 9'h001) begin
      bit_cnt_nxt = '0;
      row_nxt.gray = mode_r;
      row_nxt.last_lsb = mode_r ? lsb_r : lane_data;
      row_nxt.last_msb = mode_r ? lane_data : '0;
      row_nxt.hits = hits_nxt;
      hits_nxt = '0;
      tgl_nxt = ~tgl_r;
    end
  end

  always_ff @(negedge lane_shift_clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= '0;
      lsb_r <= '0;
      hits_r <= '0;
      row_r <= ROW_RST;
      tgl_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      lsb_r <= lsb_nxt;
      hits_r <= hits_nxt;
      row_r <= row_nxt;
      tgl_r <= tgl_nxt;
    end
  end

  // the row word stays still for a whole row, so the toggle alone qualifies it
  assign row_word = row_r;
  assign row_tgl = tgl_r;

endmodule : pdfs_lane_capture

// file: design/pdfs_sequencer.sv
// print trigger sequencing, fire pulse timing and lane pass-through
//
// Summary of operation
// - A print trigger arriving while sequence-active is low is ignored.
// - A new trigger may come once sequence-active is high, and fire pulses stay 9 us apart.
// - The fire pulse starts 13.8 us after the accepted trigger.
// - Sequence-active goes high 3.5 us before the fire pulse ends.
// - Lanes are sampled on falling shift clock edges only, whatever the idle level.
// - Grayscale nozzles take lsb then msb, level being twice msb plus lsb.
// - Binary nozzles take one bit per falling edge, 128 edges per row.
// - Lane data and shift clock pass to the printhead unchanged.
// - The print trigger drives the head latch, so the next row may shift in early.
`timescale 1ns/100ps
module pdfs_sequencer
  import pdfs_pkg::*;
#(
  parameter int WAVE_CYC = PULSE_MIN_CYC, // fire waveform length in mclk cycles
  parameter int FPDELAY_CYCLES = FPDELAY_CYC, // trigger to fire start
  parameter int BUSYEARLY_CYCLES = BUSYEARLY_CYC, // release ahead of fire end
  parameter int MIN_GAP_CYCLES = MIN_GAP_CYC // least gap between fire pulses
) (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic print_trigger, // print pulse from host, active high, asynchronous
  input wire logic grayscale_mode, // format pin, 1 = grayscale
  input wire logic lane_shift_clock, // host shift clock
  input wire logic [NUM_LANES-1:0] lane_data, // serial lanes from host
  output logic seq_active_n, // sequence active, active low
  output logic fire_active, // fire pulse waveform running
  output logic fire_start, // one-cycle pulse at waveform start
  output logic head_shift_clock, // shift clock to the printhead
  output logic [NUM_LANES-1:0] head_data, // lanes to the printhead
  output logic head_latch, // latch to the printhead
  output logic row_valid, // one-cycle pulse, new row word
  output pdfs_row_s row_word, // last row seen at the lanes
  output logic [7:0] rows_in_seq, // rows received since last accepted trigger
  output logic [7:0] ignored_count, // triggers ignored while busy, saturating
  output logic gray_mode_sync // synchronised format pin
);

  typedef enum {DL_IDLE, DL_WAIT, DL_HOLD} pdfs_delay_e;
  typedef enum {FR_IDLE, FR_ON} pdfs_fire_e;

  localparam logic [TIMER_W-1:0] FPD_LAST = TIMER_W'(FPDELAY_CYCLES - 1);
  localparam logic [TIMER_W-1:0] WAVE_LAST = TIMER_W'(WAVE_CYC - 1);
  localparam logic [TIMER_W-1:0] REL_AT =
    TIMER_W'((WAVE_CYC > BUSYEARLY_CYCLES) ? (WAVE_CYC - BUSYEARLY_CYCLES) : 0);
  localparam logic [TIMER_W-1:0] GAP_MIN = TIMER_W'(MIN_GAP_CYCLES);

  assign head_shift_clock = lane_shift_clock;
  assign head_data = lane_data;
  assign head_latch = print_trigger;

  // input synchronisers
  logic trig_meta_r, trig_sync_r, trig_prev_r;
  logic mode_meta_r, mode_sync_r;
  logic rtgl_meta_r, rtgl_sync_r, rtgl_prev_r;
  logic cap_tgl;
  pdfs_row_s cap_word;

  pdfs_lane_capture u_capture (
    .lane_shift_clock(lane_shift_clock),
    .rst_n(rst_n),
    .grayscale_mode(grayscale_mode),
    .lane_data(lane_data),
    .row_word(cap_word),
    .row_tgl(cap_tgl)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_meta_r <= 1'b0;
      trig_sync_r <= 1'b0;
      trig_prev_r <= 1'b0;
      mode_meta_r <= 1'b0;
      mode_sync_r <= 1'b0;
      rtgl_meta_r <= 1'b0;
      rtgl_sync_r <= 1'b0;
      rtgl_prev_r <= 1'b0;
    end else begin
      trig_meta_r <= print_trigger;
      trig_sync_r <= trig_meta_r;
      trig_prev_r <= trig_sync_r;
      mode_meta_r <= grayscale_mode;
      mode_sync_r <= mode_meta_r;
      rtgl_meta_r <= cap_tgl;
      rtgl_sync_r <= rtgl_meta_r;
      rtgl_prev_r <= rtgl_sync_r;
    end
  end

  logic trig_rise;
  logic row_evt;
  assign trig_rise = trig_sync_r & ~trig_prev_r;
  assign row_evt = rtgl_sync_r ^ rtgl_prev_r;
  assign gray_mode_sync = mode_sync_r;

  // sequence acceptance and delay; fire state sits here because the hold reads it
  pdfs_delay_e dl_r, dl_nxt;
  pdfs_fire_e fr_r, fr_nxt;
  logic [TIMER_W-1:0] fcnt_r, fcnt_nxt;
  logic [TIMER_W-1:0] gap_r, gap_nxt;
  logic fstart_r, fstart_nxt;
  logic [TIMER_W-1:0] dcnt_r, dcnt_nxt;
  logic busy_n_r, busy_n_nxt;
  logic accept;
  logic go_fire;
  logic release_evt;

  assign accept = trig_rise & busy_n_r;

  always_comb begin
    dl_nxt = dl_r;
    dcnt_nxt = dcnt_r;
    go_fire = 1'b0;
    unique case (dl_r)
      DL_IDLE: begin
        if (accept) begin
          dl_nxt = DL_WAIT;
          dcnt_nxt = '0;
        end
      end
      DL_WAIT: begin
        dcnt_nxt = dcnt_r + 16'h0001;
        if (dcnt_r >= FPD_LAST) begin
          dl_nxt = DL_HOLD;
        end
      end
      DL_HOLD: begin
        if (fr_r == FR_IDLE && gap_r >= GAP_MIN) begin
          go_fire = 1'b1;
          dl_nxt = DL_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    busy_n_nxt = busy_n_r;
    if (release_evt) begin
      busy_n_nxt = 1'b1;
    end
    if (accept) begin
      busy_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dl_r <= DL_IDLE;
      dcnt_r <= '0;
      busy_n_r <= 1'b1;
    end else begin
      dl_r <= dl_nxt;
      dcnt_r <= dcnt_nxt;
      busy_n_r <= busy_n_nxt;
    end
  end

  // fire pulse waveform

  always_comb begin
    fr_nxt = fr_r;
    fcnt_nxt = fcnt_r;
    gap_nxt = gap_r;
    fstart_nxt = 1'b0;
    release_evt = 1'b0;
    unique case (fr_r)
      FR_IDLE: begin
        // gap saturates, measured from the end of the last waveform
        if (gap_r != GAP_RST) begin
          gap_nxt = gap_r + 16'h0001;
        end
        if (go_fire) begin
          fr_nxt = FR_ON;
          fcnt_nxt = '0;
          fstart_nxt = 1'b1;
          // waveform shorter than the lead releases at once
          release_evt = (REL_AT == '0);
        end
      end
      FR_ON: begin
        fcnt_nxt = fcnt_r + 16'h0001;
        if (fcnt_r == REL_AT && REL_AT != '0) begin
          release_evt = 1'b1;
        end
        if (fcnt_r >= WAVE_LAST) begin
          fr_nxt = FR_IDLE;
          gap_nxt = 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fr_r <= FR_IDLE;
      fcnt_r <= '0;
      gap_r <= GAP_RST;
      fstart_r <= 1'b0;
    end else begin
      fr_r <= fr_nxt;
      fcnt_r <= fcnt_nxt;
      gap_r <= gap_nxt;
      fstart_r <= fstart_nxt;
    end
  end

  // row tracking and trigger statistics
  pdfs_row_s row_r, row_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] rows_r, rows_nxt;
  logic [7:0] ign_r, ign_nxt;

  always_comb begin
    row_nxt = row_r;
    rvalid_nxt = 1'b0;
    rows_nxt = rows_r;
    ign_nxt = ign_r;
    // the word is steady for a full row after its toggle, so sampling here is safe
    if (row_evt) begin
      row_nxt = cap_word;
      rvalid_nxt = 1'b1;
      if (rows_r != 8'hFF) begin
        rows_nxt = rows_r + 8'h01;
      end
    end
    // an accepted trigger restarts the count, keeping a row that arrives in the same cycle
    if (accept) begin
      rows_nxt = row_evt ? 8'h01 : 8'h00;
    end
    if (trig_rise && !busy_n_r && ign_r != 8'hFF) begin
      ign_nxt = ign_r + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      row_r <= ROW_RST;
      rvalid_r <= 1'b0;
      rows_r <= '0;
      ign_r <= '0;
    end else begin
      row_r <= row_nxt;
      rvalid_r <= rvalid_nxt;
      rows_r <= rows_nxt;
      ign_r <= ign_nxt;
    end
  end

  assign seq_active_n = busy_n_r;
  assign fire_active = (fr_r == FR_ON);
  assign fire_start = fstart_r;
  assign row_valid = rvalid_r;
  assign row_word = row_r;
  assign rows_in_seq = rows_r;
  assign ignored_count = ign_r;

endmodule : pdfs_sequencer

// file: verif/pdfs_seq_checker.sv
// port assertions for the print sequencer
`timescale 1ns/100ps
module pdfs_seq_checker
  import pdfs_pkg::*;
#(
  parameter int WAVE_CYC = 40,
  parameter int FPDELAY_CYCLES = 30,
  parameter int BUSYEARLY_CYCLES = 8,
  parameter int MIN_GAP_CYCLES = 20
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic print_trigger, // host trigger
  input wire logic lane_shift_clock, // host shift clock
  input wire logic [NUM_LANES-1:0] lane_data, // host lanes
  input wire logic seq_active_n, // busy, active low
  input wire logic fire_active, // waveform running
  input wire logic fire_start, // waveform start pulse
  input wire logic head_shift_clock, // head clock
  input wire logic [NUM_LANES-1:0] head_data, // head lanes
  input wire logic head_latch, // head latch
  input wire logic row_valid, // row done pulse
  input wire logic [7:0] ignored_count // refused triggers
);
  localparam int FD = FPDELAY_CYCLES + 1;
  localparam int BL = BUSYEARLY_CYCLES - 2;
  localparam int BH = BUSYEARLY_CYCLES + 1;
  logic [15:0] fcnt_r, fcnt_nxt, gap_r, gap_nxt;
  // gap saturates so a long idle never wraps into a false short gap
  always_comb begin
    fcnt_nxt = fire_active ? fcnt_r + 16'h0001 : 16'h0000;
    gap_nxt = fire_active ? 16'h0000 : gap_r + {15'h0000, gap_r != 16'hFFFF};
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_r <= 16'h0000;
      gap_r <= 16'hFFFF;
    end else begin
      fcnt_r <= fcnt_nxt;
      gap_r <= gap_nxt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  busy_soon_a: assert property ($rose(print_trigger) && seq_active_n |-> ##[1:10] !seq_active_n)
    else $error("busy not raised after trigger");
  fire_delay_a: assert property ($fell(seq_active_n) |-> ##[FD:FD] fire_start)
    else $error("fire start delay wrong");
  busy_ignore_a: assert property ($rose(print_trigger) && !seq_active_n |-> ##[2:6] $changed(ignored_count))
    else $error("busy trigger not refused");
  early_release_a: assert property ($rose(seq_active_n) |-> fire_active ##[BL:BH] $fell(fire_active))
    else $error("busy release not ahead of fire end");
  fire_length_a: assert property ($fell(fire_active) |-> fcnt_r == 16'(WAVE_CYC))
    else $error("fire waveform length wrong");
  fire_gap_a: assert property ($rose(fire_active) |-> gap_r >= 16'(MIN_GAP_CYCLES))
    else $error("fire pulses too close");
  pass_through_a: assert property (head_data == lane_data && head_shift_clock == lane_shift_clock
    && head_latch == print_trigger)
    else $error("head lines differ from host lines");
  start_pulse_a: assert property ($rose(fire_active) |-> fire_start ##1 !fire_start && fire_active)
    else $error("fire start pulse wrong");
  row_pulse_a: assert property (row_valid |=> !row_valid)
    else $error("row pulse too long");
endmodule : pdfs_seq_checker
bind pdfs_sequencer pdfs_seq_checker #(.WAVE_CYC(WAVE_CYC), .FPDELAY_CYCLES(FPDELAY_CYCLES),
  .BUSYEARLY_CYCLES(BUSYEARLY_CYCLES), .MIN_GAP_CYCLES(MIN_GAP_CYCLES)) chk (.mclk, .rst_n,
  .print_trigger, .lane_shift_clock, .lane_data, .seq_active_n, .fire_active, .fire_start,
  .head_shift_clock, .head_data, .head_latch, .row_valid, .ignored_count);

// file: verif/pdfs_host_model.sv
// host model: shift clock frames and lane data
`timescale 1ns/100ps
module pdfs_host_model
  import pdfs_pkg::*;
(
  output logic lane_shift_clock, // 32 ns, runs only within frames
  output logic [NUM_LANES-1:0] lane_data // serial lanes
);
  initial begin
    lane_shift_clock = 1'b0;
    lane_data = 8'h00;
  end
  // one row per frame, idle level as asked
  // idle may go low to high only; the other way would add a falling edge
  task automatic send_row(input logic [NUM_LANES-1:0] d [256], input int n, input logic idle);
    lane_shift_clock = idle;
    lane_data = d[0];
    for (int i = 0; i < n; i++) begin
      #6 lane_shift_clock = 1'b1;
      #16 lane_shift_clock = 1'b0;
      // once the hold time is over the lines move on, to junk after the last bit
      #10 lane_data = (i + 1 < n) ? d[i + 1] : ~d[i];
    end
    #6 lane_shift_clock = idle;
  endtask : send_row
endmodule : pdfs_host_model

// file: verif/testbench.sv
// self-checking bench for the print sequencer
`timescale 1ns/100ps
module testbench
  import pdfs_pkg::*;
;
  logic mclk, rst_n, print_trigger, grayscale_mode, lane_shift_clock, head_shift_clock;
  logic head_latch, seq_active_n, fire_active, fire_start, row_valid, gray_mode_sync;
  logic [NUM_LANES-1:0] lane_data, head_data, rb [256];
  logic [7:0] rows_in_seq, ignored_count;
  pdfs_row_s row_word;
  int err_total, n_tests, seed, n_fire, i;

  pdfs_host_model host (.lane_shift_clock, .lane_data);
  pdfs_sequencer #(.WAVE_CYC(40), .FPDELAY_CYCLES(30), .BUSYEARLY_CYCLES(8),
    .MIN_GAP_CYCLES(20)) dut (.mclk, .rst_n, .print_trigger, .grayscale_mode,
    .lane_shift_clock, .lane_data, .seq_active_n, .fire_active, .fire_start,
    .head_shift_clock, .head_data, .head_latch, .row_valid, .row_word, .rows_in_seq,
    .ignored_count, .gray_mode_sync);

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  function automatic logic [7:0] exp_hits(input logic g, input int ln);
    logic [7:0] h;
    h = 8'h00;
    for (int k = 0; k < 128; k++)
      h += g ? 8'(rb[2*k][ln] | rb[2*k+1][ln]) : 8'(rb[k][ln]);
    return h;
  endfunction : exp_hits

  task automatic trig;
    @(negedge mclk) print_trigger = 1'b1;
    repeat (10) @(negedge mclk);
    print_trigger = 1'b0;
  endtask : trig

  // lane order is the host's affair; data goes through untouched
  task automatic row(input logic g, input logic idle, input logic full);
    for (int k = 0; k < 256; k++) rb[k] = full ? 8'hFF : 8'($random(seed));
    host.send_row(rb, g ? 256 : 128, idle);
    repeat (8) @(negedge mclk);
    for (int l = 0; l < NUM_LANES; l++) check("hits", row_word.hits[l], exp_hits(g, l));
    check("gray", 8'(row_word.gray), 8'(g));
    check("lsb", row_word.last_lsb, g ? rb[254] : rb[127]);
    check("msb", row_word.last_msb, g ? rb[255] : 8'h00);
  endtask : row

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(negedge mclk) if (fire_start === 1'b1) n_fire++;

  // the whole run needs about 40 us; allow five times that
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    seed = 73;
    rst_n = 1'b0;
    print_trigger = 1'b0;
    grayscale_mode = 1'b0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    check("idle", 8'(seq_active_n), 8'h01);
    trig;
    check("busy", 8'(seq_active_n), 8'h00);
    trig;
    check("ignored", ignored_count, 8'h01);
    trig;
    i = 0;
    while (seq_active_n !== 1'b1 && i < 200) begin
      @(negedge mclk);
      i++;
    end
    // next trigger only after release, while the scaled fire waveform is still running
    check("release", 8'(seq_active_n), 8'h01);
    check("fire on", 8'(fire_active), 8'h01);
    trig;
    check("overlap", 8'(seq_active_n), 8'h00);
    check("ignored", ignored_count, 8'h02);
    // next data no sooner than 300 ns after the pulse
    repeat (30) @(negedge mclk);
    row(1'b0, 1'b0, 1'b0);
    row(1'b0, 1'b0, 1'b1);
    row(1'b0, 1'b1, 1'b0);
    check("fires", 8'(n_fire), 8'h02);
    check("rows", rows_in_seq, 8'h03);
    grayscale_mode = 1'b1;
    // the mode is seen two shift edges late, so one grayscale-length row realigns the count
    host.send_row(rb, 256, 1'b1);
    row(1'b1, 1'b1, 1'b0);
    row(1'b1, 1'b1, 1'b0);
    check("sync", 8'(gray_mode_sync), 8'h01);
    report_and_stop();
  end
endmodule : testbench
